// *** hdl/cdo_param_bank.sv ***
// Display and output 1 parameter register bank with write validation
`timescale 1ns/1ps
`default_nettype none

module cdo_param_bank
	import cdo_pkg::*;
#(
	parameter int WIRE_MAX = 9999
) (
	// Clock, reset, enable
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     ce,
	// Model and input kind from the surrounding controller
	input  wire logic     model_compact,
	input  wire logic     input_linear,
	// Register access from the link
	input  wire cdo_req_t req,
	output var  cdo_resp_t resp,
	// Configuration to the control logic
	output var  cdo_cfg_t cfg
);

	if (WIRE_MAX < 100 || WIRE_MAX > 65535) begin : g_chk
		$error("WIRE_MAX out of range");
	end

	// Defaults must sit inside the ranges that writes accept
	if (32'(RST_FILTER) < FILTER_MIN
		|| 32'(RST_FILTER) > FILTER_MAX) begin : g_chk_filter
		$error("Filter default out of range");
	end

	if (16'(RST_CYCLE) > CYCLE_MAX || 16'(RST_LOW) > PERCENT_MAX
		|| 16'(RST_HIGH) > PERCENT_MAX) begin : g_chk_output
		$error("Output default out of range");
	end

	if (16'(RST_DELAY) > SECONDS_MAX || 16'(RST_INHIBIT) > SECONDS_MAX
		|| 16'(RST_LATCH) < ENC_MIN || 16'(RST_LATCH) > LATCH_MAX
		|| 16'(RST_KIND) < ENC_MIN
		|| 16'(RST_KIND) > KIND_MAX) begin : g_chk_alarm
		$error("Alarm default out of range");
	end

	if (16'(RST_UNIT) < ENC_MIN || 16'(RST_UNIT) > UNIT_MAX
		|| 16'(RST_LIN_DP) > LIN_DP_MAX
		|| 16'(RST_BLANK) > SECONDS_MAX) begin : g_chk_display
		$error("Display default out of range");
	end

	cdo_state_t q;
	cdo_state_t d;

	logic [1:0]  scale_places;
	logic [31:0] filter_wire;
	logic [6:0]  filter_new;
	logic        filter_ok;

	// Decimal places applied to fractional values
	assign scale_places = input_linear ? q.cfg.lin_dp : 2'h0;

	cdo_fv_scale #(
		.WIRE_MAX (WIRE_MAX)
	) u_scale (
		.places     (scale_places),
		.limit_wire (input_linear),
		.units      (q.cfg.filter_units),
		.wire_out   (filter_wire),
		.wire_in    ({q.filter_hold, req.wdata}),
		.units_in   (filter_new),
		.in_ok      (filter_ok)
	);

	always_comb begin
		logic        hit;
		logic        ok;
		logic [15:0] rd;
		logic [15:0] w;
		d  = q;
		hit = 1'b1;
		ok  = 1'b1;
		rd  = 16'h0000;
		w   = req.wdata;
		d.resp.valid = 1'b0;
		d.cfg.pv_sv_places = input_linear ? q.cfg.lin_dp
			: {1'b0, q.cfg.temp_dp};
		d.cfg.fv_places = scale_places;
		if (req.valid) begin
			unique case (req.addr)
				// Filter high word parks until the low word
				ADDR_FILTER_HI: begin
					rd = filter_wire[31:16];
					if (req.write) begin
						d.filter_hold = w;
					end
				end

				// Low word validates and commits the pair
				ADDR_FILTER_LO: begin
					rd = filter_wire[15:0];
					if (req.write) begin
						ok = filter_ok;
						if (ok) begin
							d.cfg.filter_units = filter_new;
						end
						d.filter_hold = 16'h0000;
					end
				end

				// Alarm code only on compact models
				ADDR_OUT1_TYPE: begin
					rd = 16'(q.cfg.out1_type);
					ok = (w == TYPE_INACTIVE) || (w == TYPE_PID)
						|| (w == TYPE_ONOFF)
						|| ((w == TYPE_ALARM) && model_compact);
					if (req.write && ok) begin
						d.cfg.out1_type = w[2:0];
					end
				end

				// Direct or reverse action
				ADDR_OUT1_DIR: begin
					rd = 16'(q.cfg.out1_dir);
					ok = (w >= ENC_MIN) && (w <= DIR_MAX);
					if (req.write && ok) begin
						d.cfg.out1_dir = w[1:0];
					end
				end

				// Alarm group absent on large models
				ADDR_ALARM_LATCH: begin
					hit = model_compact;
					rd  = 16'(q.cfg.alarm_latch);
					ok  = (w >= ENC_MIN) && (w <= LATCH_MAX);
					if (req.write && ok && hit) begin
						d.cfg.alarm_latch = w[1:0];
					end
				end

				// Alarm operation code
				ADDR_ALARM_KIND: begin
					hit = model_compact;
					rd  = 16'(q.cfg.alarm_kind);
					ok  = (w >= ENC_MIN) && (w <= KIND_MAX);
					if (req.write && ok && hit) begin
						d.cfg.alarm_kind = w[2:0];
					end
				end

				// Alarm delay in seconds
				ADDR_ALARM_DELAY: begin
					hit = model_compact;
					rd  = 16'(q.cfg.alarm_delay);
					ok  = (w <= SECONDS_MAX);
					if (req.write && ok && hit) begin
						d.cfg.alarm_delay = w[13:0];
					end
				end

				// Alarm inhibit in seconds
				ADDR_ALARM_INHIBIT: begin
					hit = model_compact;
					rd  = 16'(q.cfg.alarm_inhibit);
					ok  = (w <= SECONDS_MAX);
					if (req.write && ok && hit) begin
						d.cfg.alarm_inhibit = w[13:0];
					end
				end

				// Code 0 stands for the shortest cycle
				ADDR_CYCLE_TIME: begin
					rd = 16'(q.cfg.cycle_time);
					ok = (w <= CYCLE_MAX);
					if (req.write && ok) begin
						d.cfg.cycle_time = w[6:0];
					end
				end

				// Low limit percent, not checked against high
				ADDR_LOW_LIMIT: begin
					rd = 16'(q.cfg.low_limit);
					ok = (w <= PERCENT_MAX);
					if (req.write && ok) begin
						d.cfg.low_limit = w[6:0];
					end
				end

				// High limit percent
				ADDR_HIGH_LIMIT: begin
					rd = 16'(q.cfg.high_limit);
					ok = (w <= PERCENT_MAX);
					if (req.write && ok) begin
						d.cfg.high_limit = w[6:0];
					end
				end

				// Places for temperature inputs
				ADDR_TEMP_DP: begin
					rd = 16'(q.cfg.temp_dp);
					ok = (w <= TEMP_DP_MAX);
					if (req.write && ok) begin
						d.cfg.temp_dp = w[0];
					end
				end

				// Places for linear inputs
				ADDR_LIN_DP: begin
					rd = 16'(q.cfg.lin_dp);
					ok = (w <= LIN_DP_MAX);
					if (req.write && ok) begin
						d.cfg.lin_dp = w[1:0];
					end
				end

				// Unit also governs link values
				ADDR_TEMP_UNIT: begin
					rd = 16'(q.cfg.temp_unit);
					ok = (w >= ENC_MIN) && (w <= UNIT_MAX);
					if (req.write && ok) begin
						d.cfg.temp_unit = w[1:0];
					end
				end

				// Off code sits just below the timed range
				ADDR_BLANK_TIME: begin
					rd = 16'(q.cfg.blank_time);
					ok = (w == BLANK_OFF)
						|| ((w >= BLANK_MIN) && (w <= SECONDS_MAX));
					if (req.write && ok) begin
						d.cfg.blank_time = w[13:0];
					end
				end

				// Unmapped register number
				default: begin
					hit = 1'b0;
				end
			endcase
			if (!req.write) begin
				ok = 1'b1;
			end
			d.resp.valid = 1'b1;
			d.resp.err   = !hit || !ok;
			if (!hit) begin
				d.resp.exc   = EXC_BAD_ADDR;
				d.resp.rdata = 16'h0000;
			end else if (!ok) begin
				d.resp.exc   = EXC_BAD_VALUE;
				d.resp.rdata = 16'h0000;
			end else begin
				d.resp.exc   = EXC_NONE;
				d.resp.rdata = req.write ? w : rd;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q.cfg.filter_units  <= RST_FILTER;
			q.cfg.out1_type     <= RST_TYPE;
			q.cfg.out1_dir      <= RST_DIR;
			q.cfg.cycle_time    <= RST_CYCLE;
			q.cfg.alarm_latch   <= RST_LATCH;
			q.cfg.alarm_kind    <= RST_KIND;
			q.cfg.alarm_delay   <= RST_DELAY;
			q.cfg.alarm_inhibit <= RST_INHIBIT;
			q.cfg.low_limit     <= RST_LOW;
			q.cfg.high_limit    <= RST_HIGH;
			q.cfg.temp_dp       <= RST_TEMP_DP;
			q.cfg.lin_dp        <= RST_LIN_DP;
			q.cfg.temp_unit     <= RST_UNIT;
			q.cfg.blank_time    <= RST_BLANK;
			q.cfg.pv_sv_places  <= 2'h0;
			q.cfg.fv_places     <= 2'h0;
			q.filter_hold       <= 16'h0000;
			q.resp.valid        <= 1'b0;
			q.resp.err          <= 1'b0;
			q.resp.exc          <= EXC_NONE;
			q.resp.rdata        <= 16'h0000;
		end else if (ce) begin
			q <= d;
		end
	end

	assign resp = q.resp;
	assign cfg  = q.cfg;

endmodule

`default_nettype wire

// *** hdl/cdo_pkg.sv ***
// Package: register map, encodings, ranges and carriers of the parameter bank
package cdo_pkg;

	// Relative register numbers
	localparam logic [15:0] ADDR_FILTER_HI     = 16'h0023;
	localparam logic [15:0] ADDR_FILTER_LO     = 16'h0024;
	localparam logic [15:0] ADDR_OUT1_TYPE     = 16'h0fd2;
	localparam logic [15:0] ADDR_OUT1_DIR      = 16'h0fd3;
	localparam logic [15:0] ADDR_ALARM_LATCH   = 16'h0fd4;
	localparam logic [15:0] ADDR_ALARM_KIND    = 16'h0fd5;
	localparam logic [15:0] ADDR_ALARM_DELAY   = 16'h0fd6;
	localparam logic [15:0] ADDR_ALARM_INHIBIT = 16'h0fd7;
	localparam logic [15:0] ADDR_CYCLE_TIME    = 16'h0fd8;
	localparam logic [15:0] ADDR_LOW_LIMIT     = 16'h0fd9;
	localparam logic [15:0] ADDR_HIGH_LIMIT    = 16'h0fda;
	localparam logic [15:0] ADDR_TEMP_DP       = 16'h0fe4;
	localparam logic [15:0] ADDR_LIN_DP        = 16'h0fe5;
	localparam logic [15:0] ADDR_TEMP_UNIT     = 16'h0fe6;
	localparam logic [15:0] ADDR_BLANK_TIME    = 16'h0fe7;

	// Reset values
	localparam logic [6:0]  RST_FILTER   = 7'h01;
	localparam logic [2:0]  RST_TYPE     = 3'h2;
	localparam logic [1:0]  RST_DIR      = 2'h2;
	localparam logic [1:0]  RST_LATCH    = 2'h1;
	localparam logic [2:0]  RST_KIND     = 3'h2;
	localparam logic [13:0] RST_DELAY    = 14'h0000;
	localparam logic [13:0] RST_INHIBIT  = 14'h0000;
	localparam logic [6:0]  RST_CYCLE    = 7'h05;
	localparam logic [6:0]  RST_LOW      = 7'h00;
	localparam logic [6:0]  RST_HIGH     = 7'h64;
	localparam logic        RST_TEMP_DP  = 1'b0;
	localparam logic [1:0]  RST_LIN_DP   = 2'h0;
	localparam logic [1:0]  RST_UNIT     = 2'h1;
	localparam logic [13:0] RST_BLANK    = 14'h0009;

	// Accepted ranges
	localparam logic [31:0] FILTER_MIN   = 32'h0000_0001;
	localparam logic [31:0] FILTER_MAX   = 32'h0000_0064;
	localparam logic [15:0] CYCLE_MAX    = 16'h0078;
	localparam logic [15:0] PERCENT_MAX  = 16'h0064;
	localparam logic [15:0] SECONDS_MAX  = 16'h270f;
	localparam logic [15:0] BLANK_OFF    = 16'h0009;
	localparam logic [15:0] BLANK_MIN    = 16'h000a;
	localparam logic [15:0] TEMP_DP_MAX  = 16'h0001;
	localparam logic [15:0] LIN_DP_MAX   = 16'h0003;

	// Output function encodings
	localparam logic [15:0] TYPE_INACTIVE = 16'h0001;
	localparam logic [15:0] TYPE_PID      = 16'h0002;
	localparam logic [15:0] TYPE_INVALID  = 16'h0003;
	localparam logic [15:0] TYPE_ONOFF    = 16'h0004;
	localparam logic [15:0] TYPE_ALARM    = 16'h0005;
	// Direction 1..2, latching 1..3, alarm kind 1..6, unit 1..3
	localparam logic [15:0] DIR_MAX       = 16'h0002;
	localparam logic [15:0] LATCH_MAX     = 16'h0003;
	localparam logic [15:0] KIND_MAX      = 16'h0006;
	localparam logic [15:0] UNIT_MAX      = 16'h0003;
	localparam logic [15:0] ENC_MIN       = 16'h0001;

	// Decimal scale factors for 0..3 places
	localparam logic [13:0] SCALE_DP0 = 14'h0001;
	localparam logic [13:0] SCALE_DP1 = 14'h000a;
	localparam logic [13:0] SCALE_DP2 = 14'h0064;
	localparam logic [13:0] SCALE_DP3 = 14'h03e8;

	// Exception codes returned to the master
	localparam logic [7:0] EXC_NONE       = 8'h00;
	localparam logic [7:0] EXC_BAD_ADDR   = 8'h02;
	localparam logic [7:0] EXC_BAD_VALUE  = 8'h03;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cdo_req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [7:0]  exc;
		logic [15:0] rdata;
	} cdo_resp_t;

	typedef struct packed {
		logic [6:0]  filter_units;
		logic [2:0]  out1_type;
		logic [1:0]  out1_dir;
		logic [6:0]  cycle_time;
		logic [1:0]  alarm_latch;
		logic [2:0]  alarm_kind;
		logic [13:0] alarm_delay;
		logic [13:0] alarm_inhibit;
		logic [6:0]  low_limit;
		logic [6:0]  high_limit;
		logic        temp_dp;
		logic [1:0]  lin_dp;
		logic [1:0]  temp_unit;
		logic [13:0] blank_time;
		logic [1:0]  pv_sv_places;
		logic [1:0]  fv_places;
	} cdo_cfg_t;

	typedef struct packed {
		cdo_cfg_t    cfg;
		logic [15:0] filter_hold;
		cdo_resp_t   resp;
	} cdo_state_t;

endpackage

// *** hdl/cdo_fv_scale.sv ***
// Scaling of fractional-valued parameters by the applied decimal places
`timescale 1ns/1ps
`default_nettype none

module cdo_fv_scale
	import cdo_pkg::*;
#(
	parameter int WIRE_MAX = 9999
) (
	// Applied decimal places
	input  wire logic [1:0]  places,
	input  wire logic        limit_wire,
	// Stored value to link value
	input  wire logic [6:0]  units,
	output logic      [31:0] wire_out,
	// Link value to stored value
	input  wire logic [31:0] wire_in,
	output logic      [6:0]  units_in,
	output logic             in_ok
);

	if (WIRE_MAX < 100 || WIRE_MAX > 65535) begin : g_chk
		$error("WIRE_MAX out of range");
	end

	logic [13:0] scale;
	logic [31:0] quot;
	logic        exact;
	logic        shrink_ok;

	always_comb begin
		unique case (places)
			2'h0: scale = SCALE_DP0;
			2'h1: scale = SCALE_DP1;
			2'h2: scale = SCALE_DP2;
			2'h3: scale = SCALE_DP3;
		endcase
		unique case (places)
			2'h0: quot = wire_in;
			2'h1: quot = wire_in / 32'(SCALE_DP1);
			2'h2: quot = wire_in / 32'(SCALE_DP2);
			2'h3: quot = wire_in / 32'(SCALE_DP3);
		endcase
		wire_out  = 32'(32'(units) * 32'(scale));
		exact     = (32'(quot * 32'(scale)) == wire_in);
		// Linear input: range shrinks to what the link can carry
		shrink_ok = !limit_wire || (wire_in <= 32'(WIRE_MAX));
		in_ok     = exact && shrink_ok && (quot >= FILTER_MIN)
			&& (quot <= FILTER_MAX);
		units_in  = quot[6:0];
	end

endmodule

`default_nettype wire

// *** verification/cdo_checker.sv ***
// Port assertions for the parameter bank
`timescale 1ns/1ps
`default_nettype none
module cdo_checker
	import cdo_pkg::*;
#(
	parameter int WIRE_MAX = 9999
) (
	// Clock and controls
	input wire logic      clk,
	input wire logic      rst,
	input wire logic      ce,
	input wire logic      model_compact,
	input wire logic      input_linear,
	// Access and configuration
	input wire cdo_req_t  req,
	input wire cdo_resp_t resp,
	input wire cdo_cfg_t  cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic tk  = ce && req.valid;
	wire logic alm = req.addr >= ADDR_ALARM_LATCH
		&& req.addr <= ADDR_ALARM_INHIBIT;
	chk_answer_next: assert property (tk ##1 ce |-> resp.valid)
		else $error("answer missing");
	chk_no_stray: assert property (resp.valid && $past(ce)
		|-> $past(tk))
		else $error("answer without request");
	chk_type_legal: assert property (cfg.out1_type inside
		{3'h1, 3'h2, 3'h4, 3'h5} && !($changed(cfg.out1_type)
		&& cfg.out1_type == 3'h5 && !$past(model_compact)))
		else $error("bad output type");
	chk_unit_codes: assert property (cfg.temp_unit != 2'h0)
		else $error("bad unit");
	chk_filter_range: assert property (cfg.filter_units inside
		{[7'h01:7'h64]}) else $error("filter out of range");
	chk_limit_range: assert property (cfg.cycle_time <= 7'h78
		&& cfg.low_limit <= 7'h64 && cfg.high_limit <= 7'h64)
		else $error("limit out of range");
	chk_bad_kept: assert property (tk && req.write
		&& req.addr == ADDR_CYCLE_TIME && req.wdata > CYCLE_MAX
		|=> resp.exc == EXC_BAD_VALUE && $stable(cfg.cycle_time))
		else $error("bad write taken");
	chk_alarm_gate: assert property (tk && alm && !model_compact
		|=> resp.err && resp.exc == EXC_BAD_ADDR)
		else $error("alarm reg open");
	chk_places_track: assert property ($past(ce)
		&& $stable(input_linear)
		&& $stable(cfg.lin_dp) && $stable(cfg.temp_dp)
		|-> cfg.pv_sv_places == (input_linear ? cfg.lin_dp
		: {1'b0, cfg.temp_dp}) && cfg.fv_places
		== (input_linear ? cfg.lin_dp : 2'h0))
		else $error("places wrong");
	cover property (tk && alm && !model_compact);
	cover property (resp.valid && resp.exc == EXC_BAD_VALUE);
	cover property (tk && req.write && req.addr == ADDR_FILTER_LO);
	cover property (!ce && req.valid);
endmodule
bind cdo_param_bank cdo_checker #(.WIRE_MAX(WIRE_MAX)) u_chk (
	.clk(clk), .rst(rst), .ce(ce), .model_compact(model_compact),
	.input_linear(input_linear), .req(req), .resp(resp), .cfg(cfg));
`default_nettype wire

// *** verification/cdo_master_model.sv ***
// Link master model issuing single register requests
`timescale 1ns/1ps
`default_nettype none
module cdo_master_model
	import cdo_pkg::*;
(
	// Clock
	input wire logic      clk,
	// Register access
	output var cdo_req_t  req,
	input wire cdo_resp_t resp
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [15:0] a, d,
		output cdo_resp_t r);
		int n;
		@(negedge clk);
		req <= '{1'b1, w, a, d};
		@(negedge clk);
		// Released fields show inverted leftovers
		req <= '{1'b0, ~w, ~a, ~d};
		for (n = 0; n < 8 && resp.valid !== 1'b1; n++)
			@(negedge clk);
		r = resp;
	endtask
endmodule
`default_nettype wire

// *** verification/cdo_param_bank_tb.sv ***
// Self-checking bench for the parameter bank
`timescale 1ns/1ps
`default_nettype none
module cdo_param_bank_tb
	import cdo_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce  = 1'b1;
	logic        mc  = 1'b1;
	logic        lin = 1'b0;
	cdo_req_t    req;
	cdo_resp_t   resp;
	cdo_cfg_t    cfg;
	int          fail_count = 0;
	int          n_checks = 0;
	logic [15:0] ex [logic [15:0]];
	initial forever #10 clk = ~clk;
	cdo_param_bank u_dut (.clk(clk), .rst(rst), .ce(ce),
		.model_compact(mc), .input_linear(lin), .req(req),
		.resp(resp), .cfg(cfg));
	cdo_master_model u_mst (.clk(clk), .req(req), .resp(resp));
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, d,
		input logic [7:0] e);
		cdo_resp_t r;
		u_mst.xfer(w, a, d, r);
		chk(r.valid, 1'b1);
		chk(r.exc, e);
		chk(r.err, e != EXC_NONE);
		if (e == EXC_NONE && w)
			ex[a] = d;
		chk(r.rdata, e != EXC_NONE ? 16'h0 : w ? d : ex[a]);
	endtask
	// Write then read back
	task automatic wr(input logic [15:0] a, d, input logic [7:0] e);
		acc(1'b1, a, d, e);
		acc(1'b0, a, 16'h0, e == EXC_BAD_ADDR ? e : EXC_NONE);
	endtask
	task automatic rng(input logic [15:0] a, lo, hi, from, to);
		for (int v = from; v <= to; v++)
			wr(a, 16'(v), (v >= lo && v <= hi) ? EXC_NONE
				: EXC_BAD_VALUE);
	endtask
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#(20 * 40000);
		fail_count++;
		end_sim;
	end
	initial begin
		cdo_resp_t r;
		ex = '{16'h0fd2:16'h2, 16'h0fd3:16'h2, 16'h0fd4:16'h1,
			16'h0fd5:16'h2, 16'h0fd6:16'h0, 16'h0fd7:16'h0,
			16'h0fd8:16'h5, 16'h0fd9:16'h0, 16'h0fda:16'h64,
			16'h0fe4:16'h0, 16'h0fe5:16'h0, 16'h0fe6:16'h1,
			16'h0fe7:16'h9};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk(cfg.filter_units, 7'h01);
		foreach (ex[a])
			acc(1'b0, a, 16'h0, EXC_NONE);
		$display("reset values done");
		for (int v = 0; v < 8; v++)
			wr(ADDR_OUT1_TYPE, 16'(v), v inside {1, 2, 4, 5} ?
				EXC_NONE : EXC_BAD_VALUE);
		rng(ADDR_OUT1_DIR, 1, 2, 0, 3);
		rng(ADDR_CYCLE_TIME, 0, 120, 0, 121);
		rng(ADDR_ALARM_LATCH, 1, 3, 0, 4);
		rng(ADDR_ALARM_KIND, 1, 6, 0, 7);
		rng(ADDR_ALARM_DELAY, 0, 9999, 9998, 10000);
		rng(ADDR_ALARM_INHIBIT, 0, 9999, 9998, 10000);
		rng(ADDR_LOW_LIMIT, 0, 100, 99, 101);
		rng(ADDR_HIGH_LIMIT, 0, 100, 99, 101);
		rng(ADDR_TEMP_DP, 0, 1, 0, 2);
		rng(ADDR_LIN_DP, 0, 3, 0, 4);
		rng(ADDR_TEMP_UNIT, 1, 3, 0, 4);
		chk(cfg.temp_unit, 2'h3);
		rng(ADDR_BLANK_TIME, 9, 9999, 7, 11);
		rng(ADDR_BLANK_TIME, 9, 9999, 9998, 10000);
		$display("encodings done");
		// Let the last answer retire before freezing
		@(negedge clk);
		ce = 1'b0;
		u_mst.xfer(1'b1, ADDR_CYCLE_TIME, 16'h0007, r);
		chk(r.valid, 1'b0);
		chk(cfg.cycle_time, 7'h78);
		ce = 1'b1;
		wr(ADDR_CYCLE_TIME, 16'h0007, EXC_NONE);
		$display("clock enable done");
		mc = 1'b0;
		wr(ADDR_OUT1_TYPE, 16'h5, EXC_BAD_VALUE);
		wr(ADDR_OUT1_TYPE, 16'h2, EXC_NONE);
		wr(ADDR_ALARM_DELAY, 16'h1, EXC_BAD_ADDR);
		wr(ADDR_ALARM_LATCH, 16'h2, EXC_BAD_ADDR);
		wr(16'h0fdb, 16'h1, EXC_BAD_ADDR);
		$display("refusals done");
		lin = 1'b1;
		wr(ADDR_LIN_DP, 16'h1, EXC_NONE);
		chk(cfg.pv_sv_places, 2'h1);
		chk(cfg.fv_places, 2'h1);
		acc(1'b1, ADDR_FILTER_HI, 16'h0, EXC_NONE);
		acc(1'b1, ADDR_FILTER_LO, 16'h14, EXC_NONE);
		chk(cfg.filter_units, 7'h02);
		acc(1'b0, ADDR_FILTER_LO, 16'h0, EXC_NONE);
		acc(1'b0, ADDR_FILTER_HI, 16'h0, EXC_NONE);
		acc(1'b1, ADDR_FILTER_LO, 16'h03e9, EXC_BAD_VALUE);
		acc(1'b1, ADDR_FILTER_LO, 16'h03f2, EXC_BAD_VALUE);
		chk(cfg.filter_units, 7'h02);
		wr(ADDR_LIN_DP, 16'h3, EXC_NONE);
		acc(1'b1, ADDR_FILTER_HI, 16'h1, EXC_NONE);
		acc(1'b1, ADDR_FILTER_LO, 16'h86a0, EXC_BAD_VALUE);
		chk(cfg.filter_units, 7'h02);
		acc(1'b1, ADDR_FILTER_LO, 16'h1388, EXC_NONE);
		chk(cfg.filter_units, 7'h05);
		lin = 1'b0;
		repeat (2) @(negedge clk);
		chk(cfg.fv_places, 2'h0);
		chk(cfg.pv_sv_places, 2'h1);
		$display("filter and places done");
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk(cfg.cycle_time, 7'h05);
		chk(cfg.out1_type, 3'h2);
		chk(cfg.blank_time, 14'h0009);
		$display("second reset done");
		end_sim;
	end
endmodule
`default_nettype wire
